/* File: dv/three_port_gpio_block_bench.sv */
// Bench for the three-port GPIO: AXI4-Lite master tasks, result queues, board model.
// Assumes tpg_pins on the pads; the design runs with the external reset option on.
`timescale 1ns/1ps
module three_port_gpio_block_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, v, seed = 32'h9191;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [2:0][7:0] pin_in, board_val = '0, board_en = '1;
	tpg_pkg::tpg_pad_s [2:0] pads;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int error_cnt = 0, tests_run = 0;
	always #10 aclk = ~aclk;
	tpg_gpio #(.EXT_RESET_EN(1'b1)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .pin_in(pin_in), .pads(pads), .irq(irq));
	tpg_pins pins_u (.aclk(aclk), .pads(pads), .board_val(board_val), .board_en(board_en),
		.pin_in(pin_in));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] idx, input logic [31:0] d,
		input logic [1:0] er = tpg_pkg::RESP_OKAY);
		bq.push_back(er);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= {2'h0, idx, 2'h0};
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!wready);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] ex,
		input logic [1:0] er = tpg_pkg::RESP_OKAY);
		rq.push_back({er, ex});
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= {2'h0, idx, 2'h0};
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	// Results are judged where they appear, against the oldest note
	always @(posedge aclk) begin
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (bvalid && bready)
			chk(34'(bresp), 34'(bq.pop_front()));
	end
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int p = 0; p < 3; p++) begin
			rd(tpg_pkg::DIR_IDX[p], 32'(tpg_pkg::PIN3_FORCE[p]));
			rd(tpg_pkg::PULL_IDX[p], 32'h0);
		end
		chk(34'(pads[0].pull), 34'h8);
		// Latch preloaded while input, then driven once the pin turns output
		// Board holds the shared reset pin low, so a read of 1 proves the force
		for (int p = 0; p < 3; p++) begin
			v = rnd();
			board_val[p] <= v[15:8] & ~tpg_pkg::PIN3_FORCE[p];
			wr(tpg_pkg::LVL_IDX[p], v);
			chk(34'(pads[p].out), 34'(v[7:0] & tpg_pkg::DRIVE_MASK[p]));
			chk(34'(pads[p].oe), 34'h0);
			rd(tpg_pkg::LVL_IDX[p], 32'((v[15:8] & tpg_pkg::IMPL_MASK[p]) |
				tpg_pkg::PIN3_FORCE[p]));
			wr(tpg_pkg::DIR_IDX[p], 32'hff);
			chk(34'(pads[p].oe), 34'(tpg_pkg::DRIVE_MASK[p]));
			chk(34'(pads[p].out), 34'(v[7:0] & tpg_pkg::DRIVE_MASK[p]));
			rd(tpg_pkg::DIR_IDX[p], 32'(tpg_pkg::IMPL_MASK[p]));
			repeat (4) @(posedge aclk);
			rd(tpg_pkg::LVL_IDX[p], 32'((((v[7:0] & tpg_pkg::DRIVE_MASK[p]) |
				(v[15:8] & ~tpg_pkg::DRIVE_MASK[p])) & tpg_pkg::IMPL_MASK[p]) |
				tpg_pkg::PIN3_FORCE[p]));
			wr(tpg_pkg::PULL_IDX[p], v & ~32'(tpg_pkg::PIN3_FORCE[p]));
			chk(34'(pads[p].pull), 34'((v[7:0] & tpg_pkg::IMPL_MASK[p]) |
				tpg_pkg::PIN3_FORCE[p]));
			rd(tpg_pkg::PULL_IDX[p], 32'h0);
		end
		for (int p = 0; p < 3; p++) begin
			v = rnd() % 5;
			wr(tpg_pkg::BITOP_IDX, (32'(p) << 4) | v);
			rd(tpg_pkg::DIR_IDX[p], 32'((tpg_pkg::IMPL_MASK[p] & ~(8'h1 << v)) |
				tpg_pkg::PIN3_FORCE[p]));
			wr(tpg_pkg::BITOP_IDX, (32'(p) << 4) | v | 32'h100);
			rd(tpg_pkg::DIR_IDX[p], 32'(tpg_pkg::IMPL_MASK[p]));
		end
		board_val[0][0] <= 1'b0;
		wr(tpg_pkg::DIR_IDX[0], 32'h0);
		wr(tpg_pkg::MASK_IDX, 32'h0);
		// Every edge mode, flag must set only on the selected edges (none for 00) with the interrupt masked
		for (int m = 0; m < 4; m++) begin
			wr(tpg_pkg::EDGE_IDX, 32'(m) << tpg_pkg::EDGE_LSB);
			wr(tpg_pkg::STAT_IDX, 32'h1);
			board_val[0][0] <= 1'b1;
			repeat (4) @(posedge aclk);
			chk(34'(irq), 34'h0);
			rd(tpg_pkg::STAT_IDX, 32'(m & 1));
			wr(tpg_pkg::STAT_IDX, 32'h1);
			board_val[0][0] <= 1'b0;
			repeat (4) @(posedge aclk);
			rd(tpg_pkg::STAT_IDX, 32'(m >> 1));
		end
		wr(tpg_pkg::MASK_IDX, 32'h1);
		repeat (2) @(posedge aclk);
		chk(34'(irq), 34'h1);
		wr(tpg_pkg::STAT_IDX, 32'h1);
		repeat (2) @(posedge aclk);
		chk(34'(irq), 34'h0);
		// Unmasked edge while both edges are selected
		board_val[0][0] <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(34'(irq), 34'h1);
		wr(tpg_pkg::STAT_IDX, 32'h1);
		repeat (2) @(posedge aclk);
		chk(34'(irq), 34'h0);
		rd(8'h00, 32'h0, tpg_pkg::RESP_SLVERR);
		wr(8'h01, 32'h1, tpg_pkg::RESP_SLVERR);
		repeat (2) @(posedge aclk);
		print_verdict();
	end
endmodule : three_port_gpio_block_bench

/* File: dv/tpg_pins.sv */
// Board model for the GPIO pins: resolves each pad from oe, board drive and pull-up.
// Assumes the bench sets board_val and board_en; pins are sampled on aclk.
`timescale 1ns/1ps
module tpg_pins (
	input wire logic aclk,
	input wire tpg_pkg::tpg_pad_s [2:0] pads,
	input wire logic [2:0][7:0] board_val,
	input wire logic [2:0][7:0] board_en,
	output logic [2:0][7:0] pin_in
);
	// Floating pins wobble so a stale level never passes for a real one
	logic [7:0] wobble = 8'h5a;
	always @(posedge aclk) wobble <= ~wobble;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (pads[p].oe[b])
					pin_in[p][b] = pads[p].out[b];
				else if (board_en[p][b])
					pin_in[p][b] = board_val[p][b];
				else if (pads[p].pull[b])
					pin_in[p][b] = 1'b1;
				else
					pin_in[p][b] = wobble[b];
			end
		end
	end
endmodule : tpg_pins

/* File: logic/tpg_gpio.sv */
// Three-port GPIO (port 0: 8 pins, ports 4 and 5: 5 pins) behind AXI4-Lite.
// Pin inputs are synchronous to aclk; pads resolve out/oe/pull outside.
// Function
// - Direction bit 0 input, 1 output; reset 0
// - Single direction bit set or clear possible
// - Port 0 pin 3 input only, reads 1
// - Write-only pull-up bits, reset cleared
// - Port 0 pin 3 pull-up bit held 1
// - Data read gives pins, write loads latch
// - External reset option: port 0 bit3 reads 1
// - Pin 0 edge sets flag regardless of enable
// - Edge select: 01 rise, 10 fall, 11 both
`timescale 1ns/1ps
module tpg_gpio #(
	parameter int ADDR_W = 12,
	parameter bit EXT_RESET_EN = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [2:0][7:0] pin_in,
	output tpg_pkg::tpg_pad_s [2:0] pads,
	output logic irq
);
	// ---------------------------------------------------------------
	// Bus state
	// ---------------------------------------------------------------
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, rresp_reg;
	logic arready_reg, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg;
	logic [2:0][7:0] dir_reg, dir_next, lat_reg, lat_next, pull_reg, pull_next;
	logic [1:0] edge_sel_reg, edge_sel_next;
	logic flag_reg, flag_next, mask_reg, mask_next, prev_reg, irq_reg;

	wire aw_fire = awvalid && awready_reg;
	wire w_fire = wvalid && wready_reg;
	wire ar_fire = arvalid && arready_reg;
	wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	wire lane0 = w_strb_reg[0];
	wire [7:0] wr_idx = aw_addr_reg[9:2];
	wire wr_top = (aw_addr_reg[ADDR_W-1:10] == '0);
	wire [7:0] rd_idx = araddr[9:2];
	wire rd_top = (araddr[ADDR_W-1:10] == '0);

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	logic [2:0] wr_dir, wr_lvl, wr_pull, rd_hit;
	logic [2:0][7:0] rd_part;
	wire wr_edge = wr_fire && wr_top && wr_idx == tpg_pkg::EDGE_IDX;
	wire wr_stat = wr_fire && wr_top && wr_idx == tpg_pkg::STAT_IDX;
	wire wr_mask = wr_fire && wr_top && wr_idx == tpg_pkg::MASK_IDX;
	wire wr_bop = wr_fire && wr_top && wr_idx == tpg_pkg::BITOP_IDX;
	wire wr_any = |{wr_dir, wr_lvl, wr_pull, wr_edge, wr_stat, wr_mask, wr_bop};
	// Bit op carries its value in lane 1, so both lanes must be strobed
	wire bop_fire = wr_bop && (w_strb_reg[1:0] == 2'h3);
	wire [1:0] bop_port = w_data_reg[tpg_pkg::BOP_PORT_LSB +: 2];
	wire [7:0] bop_bit = 8'h01 << w_data_reg[2:0];
	wire bop_val = w_data_reg[tpg_pkg::BOP_VAL_BIT];

	// ---------------------------------------------------------------
	// Per-port registers and pads
	// ---------------------------------------------------------------
	genvar g;
	for (g = 0; g < 3; g++) begin : g_port
		wire bop_here = bop_fire && (bop_port == 2'(g));
		wire [7:0] dir_bop = bop_val ? (dir_reg[g] | bop_bit) : (dir_reg[g] & ~bop_bit);
		wire [7:0] lvl_rd = (pin_in[g] & tpg_pkg::IMPL_MASK[g])
			| (EXT_RESET_EN ? tpg_pkg::PIN3_FORCE[g] : 8'h00);
		assign wr_dir[g] = wr_fire && wr_top && wr_idx == tpg_pkg::DIR_IDX[g];
		assign wr_lvl[g] = wr_fire && wr_top && wr_idx == tpg_pkg::LVL_IDX[g];
		assign wr_pull[g] = wr_fire && wr_top && wr_idx == tpg_pkg::PULL_IDX[g];
		// Pin 3 of port 0 never drives: its stored bit is forced to 0
		assign dir_next[g] = ((wr_dir[g] && lane0) ? w_data_reg[7:0]
			: bop_here ? dir_bop : dir_reg[g]) & tpg_pkg::DRIVE_MASK[g];
		// Latch ignores direction so a later switch drives the preload
		assign lat_next[g] = (wr_lvl[g] && lane0)
			? (w_data_reg[7:0] & tpg_pkg::DRIVE_MASK[g]) : lat_reg[g];
		assign pull_next[g] = (((wr_pull[g] && lane0) ? w_data_reg[7:0] : pull_reg[g])
			& tpg_pkg::IMPL_MASK[g]) | tpg_pkg::PIN3_FORCE[g];
		// Pull-up registers are write-only and read as zero
		assign rd_part[g] = (rd_idx == tpg_pkg::DIR_IDX[g])
			? (dir_reg[g] | tpg_pkg::PIN3_FORCE[g])
			: (rd_idx == tpg_pkg::LVL_IDX[g]) ? lvl_rd : 8'h00;
		assign rd_hit[g] = rd_idx == tpg_pkg::DIR_IDX[g] || rd_idx == tpg_pkg::LVL_IDX[g]
			|| rd_idx == tpg_pkg::PULL_IDX[g];
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				dir_reg[g] <= tpg_pkg::DIR_RST;
				lat_reg[g] <= tpg_pkg::LVL_RST;
				pull_reg[g] <= tpg_pkg::PULL_RST | tpg_pkg::PIN3_FORCE[g];
			end else begin
				dir_reg[g] <= dir_next[g];
				lat_reg[g] <= lat_next[g];
				pull_reg[g] <= pull_next[g];
			end
		end
		assign pads[g].out = lat_reg[g];
		assign pads[g].oe = dir_reg[g];
		assign pads[g].pull = pull_reg[g];
	end

	// ---------------------------------------------------------------
	// Pin 0 edge event and interrupt
	// ---------------------------------------------------------------
	wire pin0 = pin_in[0][0];
	wire rise = pin0 && !prev_reg;
	wire fall = !pin0 && prev_reg;
	wire edge_hit = (edge_sel_reg == tpg_pkg::EDGE_RISE && rise)
		|| (edge_sel_reg == tpg_pkg::EDGE_FALL && fall)
		|| (edge_sel_reg == tpg_pkg::EDGE_BOTH && (rise || fall));
	wire flag_clr = wr_stat && lane0 && w_data_reg[tpg_pkg::FLAG_BIT];
	// Set beats a same-cycle clear so no edge is lost
	assign flag_next = edge_hit || (flag_reg && !flag_clr);
	assign mask_next = (wr_mask && lane0) ? w_data_reg[tpg_pkg::FLAG_BIT] : mask_reg;
	assign edge_sel_next = (wr_edge && lane0)
		? w_data_reg[tpg_pkg::EDGE_LSB +: 2] : edge_sel_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 1'b0;
			flag_reg <= 1'b0;
			mask_reg <= 1'b0;
			edge_sel_reg <= tpg_pkg::EDGE_RST;
			irq_reg <= 1'b0;
		end else begin
			prev_reg <= pin0;
			flag_reg <= flag_next;
			mask_reg <= mask_next;
			edge_sel_reg <= edge_sel_next;
			irq_reg <= flag_next && mask_next;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	wire rd_any = rd_top && (|rd_hit || rd_idx == tpg_pkg::EDGE_IDX
		|| rd_idx == tpg_pkg::STAT_IDX || rd_idx == tpg_pkg::MASK_IDX
		|| rd_idx == tpg_pkg::BITOP_IDX);
	wire [7:0] rd_misc = (rd_idx == tpg_pkg::EDGE_IDX) ? 8'(edge_sel_reg) << tpg_pkg::EDGE_LSB
		: (rd_idx == tpg_pkg::STAT_IDX) ? 8'(flag_reg)
		: (rd_idx == tpg_pkg::MASK_IDX) ? 8'(mask_reg) : 8'h00;
	wire [7:0] rd_byte = rd_any ? (rd_part[0] | rd_part[1] | rd_part[2] | rd_misc) : 8'h00;

	assign aw_full_next = aw_fire ? 1'b1 : (wr_fire ? 1'b0 : aw_full_reg);
	assign w_full_next = w_fire ? 1'b1 : (wr_fire ? 1'b0 : w_full_reg);
	assign bvalid_next = wr_fire ? 1'b1 : ((bvalid_reg && bready) ? 1'b0 : bvalid_reg);
	assign rvalid_next = ar_fire ? 1'b1 : ((rvalid_reg && rready) ? 1'b0 : rvalid_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= !aw_full_next;
			wready_reg <= !w_full_next;
			bvalid_reg <= bvalid_next;
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			bresp_reg <= tpg_pkg::RESP_OKAY;
			rdata_reg <= 32'h0;
			rresp_reg <= tpg_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) aw_addr_reg <= awaddr;
			if (w_fire) w_data_reg <= wdata;
			if (w_fire) w_strb_reg <= wstrb;
			if (wr_fire) bresp_reg <= wr_any ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
			if (ar_fire) rdata_reg <= {24'h0, rd_byte};
			if (ar_fire) rresp_reg <= rd_any ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign irq = irq_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_dir_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_dir[1] && lane0 |=> pads[1].oe == ($past(w_data_reg[7:0]) & 8'h1f);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("dir write lost");

	property p_bitop;
		@(posedge aclk) disable iff (!aresetn)
		bop_fire && bop_port == 2'h2 |=> ((pads[2].oe ^ $past(pads[2].oe)) & ~$past(bop_bit)) == 8'h00
			&& pads[2].oe[$past(w_data_reg[2:0])] == ($past(bop_val) && $past(w_data_reg[2:0]) < 3'h5);
	endproperty
	a_bitop: assert property (p_bitop) else $error("bit op disturbed");

	property p_pin3_in;
		@(posedge aclk) disable iff (!aresetn)
		ar_fire && rd_top && rd_idx == 8'hb8 |=> !pads[0].oe[3] && rdata[3];
	endproperty
	a_pin3_in: assert property (p_pin3_in) else $error("pin 3 drives");

	property p_pull_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_pull[0] && lane0 |=> pads[0].pull == ($past(w_data_reg[7:0]) | 8'h08);
	endproperty
	a_pull_write: assert property (p_pull_write) else $error("pull write lost");

	property p_pull3;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) or 1'b1 |-> pads[0].pull[3];
	endproperty
	a_pull3: assert property (p_pull3) else $error("pin 3 pull bit low");

	property p_level_read;
		@(posedge aclk) disable iff (!aresetn)
		ar_fire && rd_top && rd_idx == 8'hd4 |=> rvalid && rdata == {27'h0, $past(pin_in[1][4:0])};
	endproperty
	a_level_read: assert property (p_level_read) else $error("level read wrong");

	property p_ext_reset;
		@(posedge aclk) disable iff (!aresetn)
		EXT_RESET_EN && ar_fire && rd_top && rd_idx == 8'hd0 |=> rdata[3];
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("bit 3 not forced");

	property p_flag_irq;
		@(posedge aclk) disable iff (!aresetn)
		edge_hit |=> flag_reg ##0 (irq == mask_reg);
	endproperty
	a_flag_irq: assert property (p_flag_irq) else $error("edge flag missed");

	property p_no_edge;
		@(posedge aclk) disable iff (!aresetn)
		edge_sel_reg == tpg_pkg::EDGE_RST && !flag_reg |=> !flag_reg;
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("reserved edge set flag");

	property p_latch_hold;
		@(posedge aclk) disable iff (!aresetn)
		wr_dir[2] |=> $stable(pads[2].out);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

	property p_latch_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_lvl[0] && lane0 |=> pads[0].out == ($past(w_data_reg[7:0]) & 8'hf7);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");

	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		!(flag_reg && mask_reg) |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

	c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##1 bvalid);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) ar_fire ##1 rvalid);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) edge_hit ##1 irq);
	c_bitop: cover property (@(posedge aclk) disable iff (!aresetn) bop_fire ##1 bvalid);
	c_both: cover property (@(posedge aclk) disable iff (!aresetn)
		edge_sel_reg == tpg_pkg::EDGE_BOTH && edge_hit);
endmodule : tpg_gpio

/* File: pkg/tpg_pkg.sv */
// Constants and types for the three-port GPIO block.
// Assumes an AXI4-Lite master with 32-bit data; index * 4 gives byte address.
package tpg_pkg;
	// ---------------------------------------------------------------
	// Register indices, entry 0 = port 0, 1 = port 4, 2 = port 5
	// ---------------------------------------------------------------
	localparam logic [2:0][7:0] DIR_IDX = {8'hc5, 8'hc4, 8'hb8};
	localparam logic [2:0][7:0] LVL_IDX = {8'hd5, 8'hd4, 8'hd0};
	localparam logic [2:0][7:0] PULL_IDX = {8'he5, 8'he4, 8'he0};
	localparam logic [7:0] EDGE_IDX = 8'hbf;
	localparam logic [7:0] STAT_IDX = 8'hc8;
	localparam logic [7:0] MASK_IDX = 8'hc9;
	localparam logic [7:0] BITOP_IDX = 8'hf0;
	// ---------------------------------------------------------------
	// Bit layouts and values after reset
	// ---------------------------------------------------------------
	localparam logic [2:0][7:0] IMPL_MASK = {8'h1f, 8'h1f, 8'hff};
	localparam logic [2:0][7:0] DRIVE_MASK = {8'h1f, 8'h1f, 8'hf7};
	localparam logic [2:0][7:0] PIN3_FORCE = {8'h00, 8'h00, 8'h08};
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] LVL_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam int EDGE_LSB = 3;
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int FLAG_BIT = 0;
	localparam int BOP_PORT_LSB = 4;
	localparam int BOP_VAL_BIT = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Pad carrier
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pull;
		logic [7:0] oe;
		logic [7:0] out;
	} tpg_pad_s;
endpackage : tpg_pkg
